// file: rtl/oscsel_pkg.sv
// Purpose: Constants for the oscillator source select block
// Assumes: One 250 MHz clock; configuration fields held stable after reset
// Notes: Group and mode codes follow the configuration field encoding
package oscsel_pkg;
  // ----------------------------------------
  // Group codes
  // ----------------------------------------
  localparam logic [1:0] GRP_SECONDARY = 2'h0;
  localparam logic [1:0] GRP_FAST_RC = 2'h1;
  localparam logic [1:0] GRP_SLOW_RC = 2'h2;
  localparam logic [1:0] GRP_PRIMARY = 2'h3;
  // ----------------------------------------
  // Primary mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_RESISTOR_CAP_PIN_IO = 4'h8;
  localparam logic [3:0] MODE_ERC = 4'h9;
  localparam logic [3:0] MODE_EC = 4'hB;
  localparam logic [3:0] MODE_OUTSIDE_CLOCK_PIN_IO = 4'hC;
  localparam logic [3:0] MODE_EC_X4 = 4'hD;
  localparam logic [3:0] MODE_EC_X8 = 4'hE;
  localparam logic [3:0] MODE_EC_X16 = 4'hF;
  localparam logic [3:0] MODE_XT = 4'h4;
  localparam logic [3:0] MODE_XT_X4 = 4'h5;
  localparam logic [3:0] MODE_XT_X8 = 4'h6;
  localparam logic [3:0] MODE_XT_X16 = 4'h7;
  localparam logic [2:0] MODE_XTL_TOP = 3'h0;
  localparam logic [2:0] MODE_HS_TOP = 3'h1;
  localparam int MODE_CHOICES = 13;
  // ----------------------------------------
  // Pin function of the crystal out pin
  // ----------------------------------------
  localparam logic [1:0] PIN2_CRYSTAL = 2'h0;
  localparam logic [1:0] PIN2_CLKOUT = 2'h1;
  localparam logic [1:0] PIN2_GPIO = 2'h2;
  localparam logic [1:0] PIN2_UNUSED = 2'h3;
  // ----------------------------------------
  // PLL gain codes
  // ----------------------------------------
  localparam logic [1:0] PLL_OFF = 2'h0;
  localparam logic [1:0] PLL_X4 = 2'h1;
  localparam logic [1:0] PLL_X8 = 2'h2;
  localparam logic [1:0] PLL_X16 = 2'h3;
  localparam logic [4:0] GAIN_X4 = 5'h04;
  localparam logic [4:0] GAIN_X8 = 5'h08;
  localparam logic [4:0] GAIN_X16 = 5'h10;
  // ----------------------------------------
  // Start-up counter and clock divider
  // ----------------------------------------
  localparam int STARTUP_BITS = 10;
  localparam int STARTUP_PERIODS = 1024;
  localparam int QUARTER_DIV = 4;
  // ----------------------------------------
  // Control register field positions
  // ----------------------------------------
  localparam int CTL_TRIM_HI_MSB = 15;
  localparam int CTL_TRIM_HI_LSB = 14;
  localparam int CTL_ACTIVE_MSB = 13;
  localparam int CTL_ACTIVE_LSB = 12;
  localparam int CTL_TRIM_LO_MSB = 11;
  localparam int CTL_TRIM_LO_LSB = 10;
  localparam int CTL_REQ_MSB = 9;
  localparam int CTL_REQ_LSB = 8;
  localparam int CTL_LOCK_BIT = 5;
  localparam int CTL_KEEP_ON_BIT = 1;
  // ----------------------------------------
  // Trim step, hundredths of a percent
  // ----------------------------------------
  localparam int TRIM_STEP_CENTI_PCT = 150;
  localparam logic [3:0] TRIM_CENTRE = 4'h0;
endpackage

// file: rtl/oscsel_startup_counter.sv
// Purpose: Counts oscillator periods before the clock is released
// Assumes: osc_tick_in is a one-cycle pulse per oscillator period
// Notes: Restart wins over a tick in the same cycle
module oscsel_startup_counter #(
  parameter int COUNT_BITS = 10,
  parameter int PERIODS = 1024
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic restart_in,
  input wire logic bypass_in,
  input wire logic osc_tick_in,
  // Status
  output logic done_out,
  output logic [COUNT_BITS-1:0] count_out
);
  initial begin
    if (PERIODS != (1 << COUNT_BITS)) begin
      $error("oscsel_startup_counter: PERIODS must equal 2**COUNT_BITS");
    end
  end

  logic [COUNT_BITS-1:0] count;
  logic done;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
      done <= 1'b0;
    end else if (restart_in) begin
      count <= '0;
      done <= 1'b0;
    end else if (bypass_in) begin
      done <= 1'b1;
    end else if (!done && osc_tick_in) begin
      count <= count + 1'b1;
      // Wrap of the full counter marks the last period
      if (count == {COUNT_BITS{1'b1}}) begin
        done <= 1'b1;
      end
    end
  end

  assign done_out = done;
  assign count_out = count;
endmodule

// file: rtl/oscsel_top.sv
// Purpose: Oscillator source selection, start-up gating, PLL and RC control
// Assumes: Reset events, oscillator ticks and PLL lock are synchronous inputs
// Notes: Clock switching and fail-safe switching live outside this block
//
// How it works
// - Pick clock from group and mode fields.
// - Group 11 primary, 00/01/10 secondary, fast, slow.
// - Decode thirteen primary mode codes.
// - Ten-bit counter waits 1024 oscillator periods.
// - Count only for crystal modes, on restarts.
// - Second pin: clock-out, I/O or crystal.
// - First pin never becomes general I/O.
// - Keep-on bit runs secondary crystal, even asleep.
// - Secondary clocks device if group 00 and keep-on.
// - Back to primary still waits start-up delay.
// - PLL gain four, eight or sixteen by mode.
// - Lock indication mirrored in read-only status bit.
// - Group status 01 at 13:12 selects fast RC.
// - Trim split across bits 15:14 and 11:10.
// - Trim signed 1.5 percent steps about centre.
// - Slow RC clocks timer, watchdog, monitor.
// - Slow RC always on at power-on reset.
// - Slow RC stops after timer unless needed.
// - Power-on or brown-out reset loads both group registers from fuses.
module oscsel_top
  import oscsel_pkg::*;
#(
  parameter int STARTUP_COUNT_BITS = STARTUP_BITS,
  parameter int STARTUP_COUNT_PERIODS = STARTUP_PERIODS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Reset and power events, one-cycle pulses; sleep_in is a level held while asleep
  input wire logic power_on_reset_in,
  input wire logic brown_out_reset_in,
  input wire logic sleep_wake_in,
  input wire logic sleep_in,
  input wire logic power_up_delay_timer_done_in,
  // Configuration fuses
  input wire logic [1:0] group_select_fuses_in,
  input wire logic [3:0] primary_mode_fuses_in,
  input wire logic clock_fail_monitor_en_in,
  input wire logic watchdog_en_in,
  // Software control bits
  input wire logic secondary_keep_on_in,
  input wire logic [1:0] requested_group_in,
  input wire logic requested_group_we_in,
  input wire logic [3:0] fast_rc_trim_in,
  input wire logic fast_rc_trim_we_in,
  input wire logic active_group_update_in,
  // Oscillator side
  input wire logic primary_osc_tick_in,
  input wire logic pll_lock_in,
  // Selection outputs
  output logic [1:0] active_group_status_out,
  output logic [1:0] requested_group_out,
  output logic [3:0] primary_mode_out,
  output logic primary_en_out,
  output logic secondary_crystal_en_out,
  output logic secondary_is_sysclk_out,
  output logic fast_internal_rc_en_out,
  output logic slow_internal_rc_en_out,
  output logic slow_rc_feeds_timers_out,
  output logic sysclk_gate_out,
  // PLL
  output logic pll_en_out,
  output logic [1:0] pll_gain_sel_out,
  output logic [4:0] pll_multiplier_out,
  output logic pll_lock_status_out,
  // Fast RC trim
  output logic [3:0] fast_rc_trim_out,
  output logic signed [11:0] fast_rc_trim_centi_pct_out,
  // Pins
  output logic [1:0] crystal_out_pin_function_out,
  output logic quarter_clock_output_out,
  output logic quarter_clock_output_oe_out,
  output logic crystal_out_pin_gpio_out,
  output logic crystal_in_pin_gpio_out,
  // Register view
  output logic [15:0] clock_control_register_out,
  output logic [STARTUP_COUNT_BITS-1:0] startup_counter_out
);
  initial begin
    if (STARTUP_COUNT_BITS < 1 || STARTUP_COUNT_BITS > 16) begin
      $error("oscsel_top: STARTUP_COUNT_BITS out of range");
    end
    // Wrap of the full counter is the only end point the counter knows
    if (STARTUP_COUNT_PERIODS != (1 << STARTUP_COUNT_BITS)) begin
      $error("oscsel_top: STARTUP_COUNT_PERIODS must equal 2**STARTUP_COUNT_BITS");
    end
  end

  // ----------------------------------------
  // Group registers
  // ----------------------------------------
  logic [1:0] active_group;
  logic [1:0] requested_group;
  logic cold_event;

  assign cold_event = power_on_reset_in | brown_out_reset_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_group <= GRP_PRIMARY;
      requested_group <= GRP_PRIMARY;
    end else if (cold_event) begin
      active_group <= group_select_fuses_in;
      requested_group <= group_select_fuses_in;
    end else begin
      if (requested_group_we_in) begin
        requested_group <= requested_group_in;
      end
      if (active_group_update_in) begin
        active_group <= requested_group;
      end
    end
  end

  // ----------------------------------------
  // Primary mode decode
  // ----------------------------------------
  logic [3:0] mode;
  logic is_crystal;
  logic [1:0] pin2_fn;
  logic [1:0] pll_sel;

  assign mode = primary_mode_fuses_in;

  always_comb begin
    is_crystal = 1'b0;
    pin2_fn = PIN2_UNUSED;
    pll_sel = PLL_OFF;
    if (mode[3:1] == MODE_XTL_TOP || mode[3:1] == MODE_HS_TOP) begin
      is_crystal = 1'b1;
      pin2_fn = PIN2_CRYSTAL;
    end else begin
      unique case (mode)
        MODE_XT: begin
          is_crystal = 1'b1;
          pin2_fn = PIN2_CRYSTAL;
        end
        MODE_XT_X4: begin
          is_crystal = 1'b1;
          pin2_fn = PIN2_CRYSTAL;
          pll_sel = PLL_X4;
        end
        MODE_XT_X8: begin
          is_crystal = 1'b1;
          pin2_fn = PIN2_CRYSTAL;
          pll_sel = PLL_X8;
        end
        MODE_XT_X16: begin
          is_crystal = 1'b1;
          pin2_fn = PIN2_CRYSTAL;
          pll_sel = PLL_X16;
        end
        MODE_EC, MODE_ERC: begin
          pin2_fn = PIN2_CLKOUT;
        end
        MODE_OUTSIDE_CLOCK_PIN_IO, MODE_RESISTOR_CAP_PIN_IO: begin
          pin2_fn = PIN2_GPIO;
        end
        MODE_EC_X4: begin
          pin2_fn = PIN2_GPIO;
          pll_sel = PLL_X4;
        end
        MODE_EC_X8: begin
          pin2_fn = PIN2_GPIO;
          pll_sel = PLL_X8;
        end
        MODE_EC_X16: begin
          pin2_fn = PIN2_GPIO;
          pll_sel = PLL_X16;
        end
        // Code 1010 is not one of the choices
        default: begin
          pin2_fn = PIN2_UNUSED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Source enables
  // ----------------------------------------
  logic primary_sel;
  logic secondary_on;
  logic secondary_sel;

  assign primary_sel = (active_group == GRP_PRIMARY);
  assign secondary_on = secondary_keep_on_in;
  assign secondary_sel = (active_group == GRP_SECONDARY) & secondary_keep_on_in;
  assign primary_en_out = primary_sel & ~sleep_in;
  assign secondary_crystal_en_out = secondary_on;
  assign secondary_is_sysclk_out = secondary_sel;
  assign fast_internal_rc_en_out = (active_group == GRP_FAST_RC) & ~sleep_in;

  // ----------------------------------------
  // Slow RC keep-alive
  // ----------------------------------------
  logic slow_rc_on;
  logic pwr_timer_done;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_timer_done <= 1'b0;
    end else if (power_on_reset_in) begin
      pwr_timer_done <= 1'b0;
    end else if (power_up_delay_timer_done_in) begin
      pwr_timer_done <= 1'b1;
    end
  end

  // Timer still running keeps it on regardless of the enables
  always_comb begin
    slow_rc_on = ~pwr_timer_done;
    if (clock_fail_monitor_en_in || watchdog_en_in || active_group == GRP_SLOW_RC) begin
      slow_rc_on = 1'b1;
    end
  end

  assign slow_internal_rc_en_out = slow_rc_on;
  assign slow_rc_feeds_timers_out = slow_rc_on;

  // ----------------------------------------
  // Start-up delay
  // ----------------------------------------
  logic restart_event;
  logic back_to_primary;
  logic startup_done;
  logic startup_bypass;

  // Switch into the primary group restarts the count too
  assign back_to_primary = active_group_update_in & ~cold_event
    & (requested_group == GRP_PRIMARY) & (active_group != GRP_PRIMARY);
  assign restart_event = cold_event | sleep_wake_in | back_to_primary;
  assign startup_bypass = ~(is_crystal & primary_sel);

  oscsel_startup_counter #(
    .COUNT_BITS(STARTUP_COUNT_BITS),
    .PERIODS(STARTUP_COUNT_PERIODS)
  ) u_startup (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .restart_in(restart_event),
    .bypass_in(startup_bypass),
    .osc_tick_in(primary_osc_tick_in),
    .done_out(startup_done),
    .count_out(startup_counter_out)
  );

  // Gate held low while counting, and in the restart cycle itself
  assign sysclk_gate_out = startup_done & ~restart_event;

  // ----------------------------------------
  // PLL gain and lock
  // ----------------------------------------
  logic pll_lock;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_lock <= 1'b0;
    end else begin
      pll_lock <= pll_lock_in & (pll_sel != PLL_OFF) & primary_sel;
    end
  end

  assign pll_en_out = (pll_sel != PLL_OFF) & primary_sel;
  assign pll_gain_sel_out = pll_sel;
  always_comb begin
    unique case (pll_sel)
      PLL_X4: pll_multiplier_out = GAIN_X4;
      PLL_X8: pll_multiplier_out = GAIN_X8;
      PLL_X16: pll_multiplier_out = GAIN_X16;
      PLL_OFF: pll_multiplier_out = 5'h00;
    endcase
  end
  assign pll_lock_status_out = pll_lock;

  // ----------------------------------------
  // Fast RC trim
  // ----------------------------------------
  logic [3:0] trim;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trim <= TRIM_CENTRE;
    end else if (fast_rc_trim_we_in) begin
      trim <= fast_rc_trim_in;
    end
  end

  assign fast_rc_trim_out = trim;
  // Two's complement code times the step size
  assign fast_rc_trim_centi_pct_out =
    12'(signed'({{8{trim[3]}}, trim}) * TRIM_STEP_CENTI_PCT);

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  logic [1:0] quarter_div;
  logic pin2_fn_active;

  assign pin2_fn_active = primary_sel;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quarter_div <= 2'h0;
    end else begin
      quarter_div <= quarter_div + 2'h1;
    end
  end

  // Pin role fixed by the mode fuses, whatever the active group
  assign crystal_out_pin_function_out = pin2_fn;
  assign quarter_clock_output_out = quarter_div[1] & pin2_fn_active;
  assign quarter_clock_output_oe_out = (pin2_fn == PIN2_CLKOUT);
  assign crystal_out_pin_gpio_out = (pin2_fn == PIN2_GPIO);
  assign crystal_in_pin_gpio_out = 1'b0;

  // ----------------------------------------
  // Register view and status
  // ----------------------------------------
  always_comb begin
    clock_control_register_out = 16'h0000;
    clock_control_register_out[CTL_TRIM_HI_MSB:CTL_TRIM_HI_LSB] = trim[3:2];
    clock_control_register_out[CTL_ACTIVE_MSB:CTL_ACTIVE_LSB] = active_group;
    clock_control_register_out[CTL_TRIM_LO_MSB:CTL_TRIM_LO_LSB] = trim[1:0];
    clock_control_register_out[CTL_REQ_MSB:CTL_REQ_LSB] = requested_group;
    clock_control_register_out[CTL_LOCK_BIT] = pll_lock;
    clock_control_register_out[CTL_KEEP_ON_BIT] = secondary_keep_on_in;
  end

  assign active_group_status_out = active_group;
  assign requested_group_out = requested_group;
  assign primary_mode_out = mode;
endmodule

// file: testbench/oscsel_assertions.sv
// Purpose: Port-level checks for the oscillator source select block
// Assumes: Sees only ports of oscsel_top, one clock domain
// Notes: Bound into every oscsel_top instance
module oscsel_checker
  import oscsel_pkg::*;
(
  // Clock, reset and events
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic power_on_reset_in,
  input wire logic brown_out_reset_in,
  input wire logic sleep_wake_in,
  // Fuses and control
  input wire logic [1:0] group_select_fuses_in,
  input wire logic [3:0] primary_mode_fuses_in,
  input wire logic clock_fail_monitor_en_in,
  input wire logic watchdog_en_in,
  input wire logic secondary_keep_on_in,
  // Watched outputs
  input wire logic [1:0] active_group_status_out,
  input wire logic [1:0] requested_group_out,
  input wire logic [3:0] primary_mode_out,
  input wire logic secondary_crystal_en_out,
  input wire logic secondary_is_sysclk_out,
  input wire logic slow_internal_rc_en_out,
  input wire logic sysclk_gate_out,
  input wire logic [1:0] pll_gain_sel_out,
  input wire logic [4:0] pll_multiplier_out,
  input wire logic pll_lock_status_out,
  input wire logic [3:0] fast_rc_trim_out,
  input wire logic signed [11:0] fast_rc_trim_centi_pct_out,
  input wire logic [1:0] crystal_out_pin_function_out,
  input wire logic crystal_in_pin_gpio_out,
  input wire logic [15:0] clock_control_register_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_cold;
    power_on_reset_in || brown_out_reset_in;
  endsequence
  // Output follows the causes in the same cycle; the check still waits for two cycles of the cause
  sequence s_slow_needed;
    (clock_fail_monitor_en_in || watchdog_en_in || active_group_status_out == GRP_SLOW_RC) [*2];
  endsequence
  property p_cold_load;
    s_cold |=> active_group_status_out == $past(group_select_fuses_in) &&
      requested_group_out == $past(group_select_fuses_in);
  endproperty
  property p_gate_restart;
    (power_on_reset_in || brown_out_reset_in || sleep_wake_in) |-> !sysclk_gate_out;
  endproperty
  property p_mode_pass;
    primary_mode_out == primary_mode_fuses_in && pll_gain_sel_out ==
      (primary_mode_fuses_in[2] ? primary_mode_fuses_in[1:0] : PLL_OFF);
  endproperty
  property p_pin1_never_io;
    crystal_in_pin_gpio_out == 1'b0;
  endproperty
  property p_crystal_pin;
    !primary_mode_out[3] |-> crystal_out_pin_function_out == PIN2_CRYSTAL;
  endproperty
  property p_keep_on;
    secondary_crystal_en_out == secondary_keep_on_in;
  endproperty
  property p_sec_sysclk;
    secondary_is_sysclk_out ==
      (active_group_status_out == GRP_SECONDARY && secondary_keep_on_in);
  endproperty
  property p_gain_map;
    pll_multiplier_out == (pll_gain_sel_out == PLL_X4 ? GAIN_X4 :
      pll_gain_sel_out == PLL_X8 ? GAIN_X8 : pll_gain_sel_out == PLL_X16 ? GAIN_X16 : 5'h00);
  endproperty
  property p_lock_bit;
    clock_control_register_out[5] == pll_lock_status_out;
  endproperty
  property p_ctl_map;
    {clock_control_register_out[15:14], clock_control_register_out[11:10]} == fast_rc_trim_out
      && clock_control_register_out[13:12] == active_group_status_out;
  endproperty
  property p_trim_pct;
    fast_rc_trim_centi_pct_out == $signed(fast_rc_trim_out) * 12'sd150;
  endproperty
  property p_slow_keep;
    s_slow_needed |-> slow_internal_rc_en_out;
  endproperty
  a_cold_load: assert property (p_cold_load) else $error("groups not loaded from fuses");
  a_gate_restart: assert property (p_gate_restart) else $error("clock gate open at restart");
  a_mode_pass: assert property (p_mode_pass) else $error("mode code not passed on");
  a_pin1_never_io: assert property (p_pin1_never_io) else $error("first pin became io");
  a_crystal_pin: assert property (p_crystal_pin) else $error("second pin not crystal");
  a_keep_on: assert property (p_keep_on) else $error("secondary crystal enable wrong");
  a_sec_sysclk: assert property (p_sec_sysclk) else $error("secondary sysclk flag wrong");
  a_gain_map: assert property (p_gain_map) else $error("pll multiplier wrong");
  a_lock_bit: assert property (p_lock_bit) else $error("lock bit not mirrored");
  a_ctl_map: assert property (p_ctl_map) else $error("control register fields wrong");
  a_trim_pct: assert property (p_trim_pct) else $error("trim step wrong");
  a_slow_keep: assert property (p_slow_keep) else $error("slow rc stopped while needed");
endmodule

bind oscsel_top oscsel_checker i_chk (.*);

// file: testbench/oscsel_tb_top.sv
// Purpose: Directed bench for the oscillator source select block
// Assumes: Inputs driven on the falling edge; start-up count shortened to 16
// Notes: Every scenario judges its own results
`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module oscsel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oscsel_pkg::*;
  logic clk_in, nrst_in, power_on_reset_in, brown_out_reset_in, sleep_wake_in, sleep_in;
  logic power_up_delay_timer_done_in, clock_fail_monitor_en_in, watchdog_en_in;
  logic secondary_keep_on_in, requested_group_we_in, fast_rc_trim_we_in;
  logic active_group_update_in, primary_osc_tick_in, pll_lock_in;
  logic [1:0] group_select_fuses_in, requested_group_in, active_group_status_out;
  logic [1:0] requested_group_out, pll_gain_sel_out, crystal_out_pin_function_out;
  logic [3:0] primary_mode_fuses_in, fast_rc_trim_in, primary_mode_out, fast_rc_trim_out;
  logic primary_en_out, secondary_crystal_en_out, secondary_is_sysclk_out;
  logic fast_internal_rc_en_out, slow_internal_rc_en_out, slow_rc_feeds_timers_out;
  logic sysclk_gate_out, pll_en_out, pll_lock_status_out, quarter_clock_output_out;
  logic quarter_clock_output_oe_out, crystal_out_pin_gpio_out, crystal_in_pin_gpio_out;
  logic [4:0] pll_multiplier_out;
  logic signed [11:0] fast_rc_trim_centi_pct_out;
  logic [15:0] clock_control_register_out;
  logic [3:0] startup_counter_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Short count keeps the run brief; must stay a power of two
  oscsel_top #(.STARTUP_COUNT_BITS(4), .STARTUP_COUNT_PERIODS(16)) i_dut (.*);
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic cold(logic [1:0] g, logic bor);
    group_select_fuses_in = g;
    {brown_out_reset_in, power_on_reset_in} = {bor, !bor};
    cyc(1);
    {brown_out_reset_in, power_on_reset_in} = 2'h0;
    cyc(1);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      primary_osc_tick_in = 1'b1;
      cyc(1);
      primary_osc_tick_in = 1'b0;
      cyc(1);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_slow_rc;
    cold(GRP_PRIMARY, 1'b0);
    `CHK("slow_on", 1'b1, slow_internal_rc_en_out)
    power_up_delay_timer_done_in = 1'b1;
    cyc(2);
    `CHK("slow_off", 1'b0, slow_internal_rc_en_out)
    watchdog_en_in = 1'b1;
    cyc(2);
    `CHK("slow_wdt", 1'b1, slow_internal_rc_en_out)
    {watchdog_en_in, clock_fail_monitor_en_in} = 2'h1;
    cyc(2);
    `CHK("slow_mon", 1'b1, slow_rc_feeds_timers_out)
    clock_fail_monitor_en_in = 1'b0;
    cold(GRP_SLOW_RC, 1'b0);
    `CHK("slow_grp", 1'b1, slow_internal_rc_en_out)
  endtask
  task automatic t_groups;
    for (int g = 0; g < 4; g++) begin
      cold(2'(g), g[0]);
      `CHK("active", 2'(g), active_group_status_out)
      `CHK("requested", 2'(g), requested_group_out)
      `CHK("ctl_req", 2'(g), clock_control_register_out[9:8])
      `CHK("primary_en", g == 3, primary_en_out)
      `CHK("fast_rc_en", g == 1, fast_internal_rc_en_out)
    end
  endtask
  task automatic t_modes;
    logic [1:0] gain;
    logic [1:0] fn;
    for (int m = 0; m < 16; m++) begin
      primary_mode_fuses_in = 4'(m);
      cyc(1);
      gain = m[2] ? 2'(m) : PLL_OFF;
      fn = !m[3] ? PIN2_CRYSTAL : (m == 9 || m == 11) ? PIN2_CLKOUT :
        (m == 10) ? PIN2_UNUSED : PIN2_GPIO;
      `CHK("gain", gain, pll_gain_sel_out)
      `CHK("mult", 5'(gain == 0 ? 0 : 2 << gain), pll_multiplier_out)
      `CHK("pll_en", gain != 0, pll_en_out)
      `CHK("pin2_fn", fn, crystal_out_pin_function_out)
      `CHK("pin2_io", fn == PIN2_GPIO, crystal_out_pin_gpio_out)
      `CHK("clkout_oe", fn == PIN2_CLKOUT, quarter_clock_output_oe_out)
      `CHK("pin1_io", 1'b0, crystal_in_pin_gpio_out)
    end
  endtask
  task automatic t_startup;
    primary_mode_fuses_in = MODE_XT;
    cold(GRP_PRIMARY, 1'b0);
    `CHK("gate_por", 1'b0, sysclk_gate_out)
    ticks(15);
    `CHK("gate_15", 1'b0, sysclk_gate_out)
    `CHK("count_15", 4'hF, startup_counter_out)
    ticks(1);
    cyc(1);
    `CHK("gate_16", 1'b1, sysclk_gate_out)
    sleep_wake_in = 1'b1;
    cyc(1);
    sleep_wake_in = 1'b0;
    ticks(8);
    `CHK("gate_wake", 1'b0, sysclk_gate_out)
    ticks(8);
    cyc(1);
    `CHK("gate_wake_done", 1'b1, sysclk_gate_out)
    primary_mode_fuses_in = MODE_EC;
    cold(GRP_PRIMARY, 1'b1);
    cyc(2);
    `CHK("gate_bypass", 1'b1, sysclk_gate_out)
  endtask
  task automatic t_secondary;
    logic q;
    primary_mode_fuses_in = MODE_XT;
    secondary_keep_on_in = 1'b1;
    sleep_in = 1'b1;
    cold(GRP_SECONDARY, 1'b0);
    `CHK("sec_en_sleep", 1'b1, secondary_crystal_en_out)
    `CHK("sec_sysclk", 1'b1, secondary_is_sysclk_out)
    `CHK("ctl_keep", 1'b1, clock_control_register_out[1])
    `CHK("quarter_clock_output_idle", 1'b0, quarter_clock_output_out)
    sleep_in = 1'b0;
    {requested_group_in, requested_group_we_in} = {GRP_PRIMARY, 1'b1};
    cyc(1);
    {requested_group_we_in, active_group_update_in} = 2'h1;
    cyc(1);
    active_group_update_in = 1'b0;
    cyc(1);
    `CHK("back_primary", GRP_PRIMARY, active_group_status_out)
    `CHK("back_gate", 1'b0, sysclk_gate_out)
    ticks(16);
    cyc(1);
    `CHK("back_gate_done", 1'b1, sysclk_gate_out)
    q = quarter_clock_output_out;
    cyc(2);
    `CHK("quarter_clock_output_toggle", ~q, quarter_clock_output_out)
  endtask
  task automatic t_trim_lock;
    logic [3:0] tv [3] = '{4'h7, 4'h8, 4'hF};
    logic [11:0] pv [3] = '{12'h41A, 12'hB50, 12'hF6A};
    for (int i = 0; i < 3; i++) begin
      {fast_rc_trim_in, fast_rc_trim_we_in} = {tv[i], 1'b1};
      cyc(1);
      fast_rc_trim_we_in = 1'b0;
      cyc(1);
      `CHK("trim_hi", tv[i][3:2], clock_control_register_out[15:14])
      `CHK("trim_lo", tv[i][1:0], clock_control_register_out[11:10])
      `CHK("trim_pct", pv[i], fast_rc_trim_centi_pct_out)
    end
    primary_mode_fuses_in = MODE_XT_X4;
    pll_lock_in = 1'b1;
    cyc(2);
    `CHK("lock_on", 1'b1, clock_control_register_out[5])
    pll_lock_in = 1'b0;
    cyc(2);
    `CHK("lock_off", 1'b0, pll_lock_status_out)
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    nrst_in = 1'b0;
    {power_on_reset_in, brown_out_reset_in, sleep_wake_in, sleep_in, pll_lock_in} = '0;
    {power_up_delay_timer_done_in, clock_fail_monitor_en_in, watchdog_en_in} = '0;
    {secondary_keep_on_in, requested_group_we_in, fast_rc_trim_we_in} = '0;
    {active_group_update_in, primary_osc_tick_in, requested_group_in, fast_rc_trim_in} = '0;
    group_select_fuses_in = GRP_PRIMARY;
    primary_mode_fuses_in = MODE_XT;
    cyc(10);
    nrst_in = 1'b1;
    cyc(1);
    t_slow_rc;
    t_groups;
    t_modes;
    t_startup;
    t_secondary;
    t_trim_lock;
    complete_run;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule
